// [pp_pkg.sv]
package pp_pkg;

   // -----------------------------------------------------------------
   // timing, in nanoseconds as specified, then in clock cycles
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS    = 2000;   // address, data and ce setup
   localparam int T_DH_NS       = 2000;   // data hold after the pulse
   localparam int T_OES_NS      = 2000;   // oe setup before verify
   localparam int T_PW_NS       = 200000; // program pulse, typical
   localparam int T_OE_NS       = 150;    // data output delay, max
   localparam int T_DF_NS       = 130;    // data output disable, max

   // least times round up, and never below one cycle
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SYNC_LAT     = 4;   // three flops plus agree stage
   localparam int SETUP_CYC    = cyc_up(T_SETUP_NS);
   localparam int DH_CYC       = cyc_up(T_DH_NS);
   localparam int OES_CYC      = cyc_up(T_OES_NS);
   localparam int PW_CYC       = cyc_up(T_PW_NS);
   localparam int OE_CYC       = cyc_up(T_OE_NS) + SYNC_LAT;
   localparam int DF_CYC       = cyc_up(T_DF_NS);
   localparam int CNT_W        = 16;

   // -----------------------------------------------------------------
   // array layout and pin levels
   // -----------------------------------------------------------------
   localparam int ADDR_W             = 17;
   localparam logic [16:0] ARRAY_TOP = 17'h0f680;
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   localparam logic [2:0] MODE_PROM  = 3'h0;
   localparam logic       STANDBY_INPUT_N_PROM  = 1'b0;
   localparam logic [1:0] PORT6_PROM = 2'h3;

   typedef enum logic {PP_CMD_READ, PP_CMD_PROGRAM} pp_cmd_e;

   typedef enum logic [3:0] {
      PP_IDLE, PP_SETUP, PP_PULSE, PP_HOLD, PP_OES, PP_READ,
      PP_RECOVER, PP_CHECK, PP_DONE
   } pp_state_e;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        pgm_n;
      logic [16:0] addr;
      logic [7:0]  data;
      logic        data_oe;
   } pp_pins_s;

endpackage

// [pp_timer.sv]
`timescale 1ns/1ps
module pp_timer
   import pp_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              expired
);

   logic [W-1:0] cnt_q;

   // a load of n expires after exactly n cycles in the timed state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= load_val - W'(1);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   assign expired = (cnt_q == '0);

endmodule

// [pp_writer.sv]
`timescale 1ns/1ps
module pp_writer
   import pp_pkg::*;
#(
   parameter int PW_CYCLES = PW_CYC,
   parameter int MAX_TRIES = 25
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire pp_cmd_e           req_cmd,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [7:0]        req_wdata,
   output logic                   rsp_valid,
   output logic [7:0]             rsp_rdata,
   output logic                   rsp_err,
   output logic                   rsp_refused,
   output pp_pins_s               pins,
   input  wire logic [7:0]        prom_data_in,
   output logic [2:0]             mode_select_pins,
   output logic                   standby_input_n,
   output logic [1:0]             port6_sel
);

   pp_state_e          state_q, state_d;
   pp_cmd_e            cmd_q;
   logic [7:0]         s1_q, s2_q, s3_q, din_q;
   logic [7:0]         tries_q;
   logic               tmr_ld, tmr_exp;
   logic [CNT_W-1:0]   tmr_val;
   logic               err_d, ref_d;
   logic               ce_n_q, oe_n_q, pgm_n_q, data_oe_q;
   logic [ADDR_W-1:0]  addr_q;
   logic [7:0]         data_q;

   // -----------------------------------------------------------------
   // fixed mode straps
   // -----------------------------------------------------------------
   // driven constant so the chip stays in programming mode throughout
   assign mode_select_pins = MODE_PROM;
   assign standby_input_n  = STANDBY_INPUT_N_PROM;
   assign port6_sel        = PORT6_PROM;

   // -----------------------------------------------------------------
   // data pin input synchroniser
   // -----------------------------------------------------------------
   // a byte counts only once the second and third stages agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         din_q <= '0;
      end else begin
         s1_q <= prom_data_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            din_q <= s3_q;
         end
      end
   end

   pp_timer #(.W(CNT_W)) u_timer (
      .clk      (clk),
      .rst      (rst),
      .load     (tmr_ld),
      .load_val (tmr_val),
      .expired  (tmr_exp)
   );

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   // each timed state loads the timer on entry and leaves on expiry
   always_comb begin
      state_d = state_q;
      tmr_ld  = 1'b0;
      tmr_val = CNT_W'(1);
      err_d   = 1'b0;
      ref_d   = 1'b0;
      unique case (state_q)
         PP_IDLE: begin
            if (req_valid) begin
               if (req_cmd == PP_CMD_PROGRAM && req_addr >= ARRAY_TOP) begin
                  state_d = PP_DONE;
                  ref_d   = 1'b1;
               end else if (req_cmd == PP_CMD_PROGRAM &&
                            req_wdata == BLANK_BYTE) begin
                  state_d = PP_DONE;
               end else if (req_cmd == PP_CMD_PROGRAM) begin
                  state_d = PP_SETUP;
                  tmr_ld  = 1'b1;
                  tmr_val = CNT_W'(SETUP_CYC);
               end else begin
                  state_d = PP_OES;
                  tmr_ld  = 1'b1;
                  tmr_val = CNT_W'(OES_CYC);
               end
            end
         end
         PP_SETUP: if (tmr_exp) begin
            state_d = PP_PULSE;
            tmr_ld  = 1'b1;
            tmr_val = CNT_W'(PW_CYCLES);
         end
         PP_PULSE: if (tmr_exp) begin
            state_d = PP_HOLD;
            tmr_ld  = 1'b1;
            tmr_val = CNT_W'(DH_CYC);
         end
         PP_HOLD: if (tmr_exp) begin
            state_d = PP_OES;
            tmr_ld  = 1'b1;
            tmr_val = CNT_W'(OES_CYC);
         end
         PP_OES: if (tmr_exp) begin
            state_d = PP_READ;
            tmr_ld  = 1'b1;
            tmr_val = CNT_W'(OE_CYC);
         end
         PP_READ: if (tmr_exp) begin
            state_d = PP_RECOVER;
            tmr_ld  = 1'b1;
            tmr_val = CNT_W'(DF_CYC);
         end
         PP_RECOVER: if (tmr_exp) begin
            state_d = PP_CHECK;
         end
         PP_CHECK: begin
            // retry the same single byte until it verifies or tries run out
            if (cmd_q == PP_CMD_READ || rsp_rdata == data_q) begin
               state_d = PP_DONE;
            end else if (32'(tries_q) + 1 < MAX_TRIES) begin
               state_d = PP_SETUP;
               tmr_ld  = 1'b1;
               tmr_val = CNT_W'(SETUP_CYC);
            end else begin
               state_d = PP_DONE;
               err_d   = 1'b1;
            end
         end
         PP_DONE: state_d = PP_IDLE;
         default: state_d = PP_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= PP_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // -----------------------------------------------------------------
   // pin drivers, registered from the next state
   // -----------------------------------------------------------------
   // idle leaves all strobes high, a combination that drives nothing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ce_n_q    <= 1'b1;
         oe_n_q    <= 1'b1;
         pgm_n_q   <= 1'b1;
         data_oe_q <= 1'b0;
      end else begin
         ce_n_q    <= (state_d == PP_IDLE) || (state_d == PP_DONE);
         oe_n_q    <= (state_d != PP_READ);
         pgm_n_q   <= (state_d != PP_PULSE);
         data_oe_q <= (state_d == PP_SETUP) || (state_d == PP_PULSE) ||
                      (state_d == PP_HOLD);
      end
   end

   // address and byte are latched once per request and held to the end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= '0;
         data_q <= '0;
         cmd_q  <= PP_CMD_READ;
      end else if (state_q == PP_IDLE && req_valid) begin
         addr_q <= req_addr;
         data_q <= req_wdata;
         cmd_q  <= req_cmd;
      end
   end

   // one driver for the whole carrier, in the struct's field order
   assign pins = {ce_n_q, oe_n_q, pgm_n_q, addr_q, data_q, data_oe_q};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tries_q <= '0;
      end else if (state_q == PP_IDLE) begin
         tries_q <= '0;
      end else if (state_q == PP_CHECK && state_d == PP_SETUP) begin
         tries_q <= tries_q + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // response
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_rdata   <= '0;
         rsp_err     <= 1'b0;
         rsp_refused <= 1'b0;
      end else begin
         if (state_q == PP_READ && tmr_exp) begin
            rsp_rdata <= din_q;
         end else if (state_q == PP_IDLE && req_valid) begin
            rsp_rdata <= BLANK_BYTE;
         end
         if (state_d == PP_DONE) begin
            rsp_err     <= err_d;
            rsp_refused <= ref_d;
         end
      end
   end

   assign req_ready = (state_q == PP_IDLE);
   assign rsp_valid = (state_q == PP_DONE);

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [CNT_W-1:0] pw_seen_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pw_seen_q <= '0;
      end else if (pins.pgm_n) begin
         pw_seen_q <= '0;
      end else begin
         pw_seen_q <= pw_seen_q + CNT_W'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_mode_straps: assert property (
      mode_select_pins == MODE_PROM && !standby_input_n &&
      port6_sel == PORT6_PROM)
      else $error("mode straps left programming levels");

   chk_write_strobes: assert property (
      !pins.pgm_n |-> !pins.ce_n && pins.oe_n && pins.data_oe)
      else $error("program pulse without write strobes");

   chk_pulse_width: assert property (
      $rose(pins.pgm_n) |-> pw_seen_q == CNT_W'(PW_CYCLES))
      else $error("program pulse width wrong");

   chk_single_byte: assert property (
      !pins.pgm_n && !$past(pins.pgm_n) |->
         $stable(pins.addr) && $stable(pins.data))
      else $error("address or data moved during a pulse");

   chk_blank_skip: assert property (
      state_q == PP_IDLE && req_valid && req_cmd == PP_CMD_PROGRAM &&
      req_wdata == BLANK_BYTE |=> state_q == PP_DONE ##1 pins.pgm_n)
      else $error("all-ones byte was not skipped");

   chk_upper_blank: assert property (
      !pins.pgm_n |-> pins.addr < ARRAY_TOP)
      else $error("pulse above the array");

   chk_verify_release: assert property (
      !pins.oe_n |-> !pins.data_oe && pins.pgm_n && !pins.ce_n)
      else $error("verify while writer drives data");

   cov_pulse:   cover property ($rose(pins.pgm_n));
   cov_refused: cover property (rsp_valid && rsp_refused);
   cov_retry:   cover property (state_q == PP_CHECK ##1 state_q == PP_SETUP);
   cov_fail:    cover property (rsp_valid && rsp_err);

endmodule

// [pp_prom_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// behavioural one-time prom seen from its programming pins
// ------------------------------------------------------------
module pp_prom_model
   import pp_pkg::*;
(
   input  wire logic        clk,
   input  wire pp_pins_s    pins,
   input  wire logic [2:0]  mode_select_pins,
   input  wire logic        standby_input_n,
   input  wire logic [1:0]  port6_sel,
   input  wire logic        slow,
   input  wire logic        stuck_en,
   input  wire logic [16:0] stuck_addr,
   output logic [7:0]       prom_data_in,
   output logic [31:0]      pulses,
   output logic [31:0]      last_pw,
   output logic [31:0]      errs
);
   logic [7:0]  mem [0:131071];
   logic [7:0]  drv;
   logic [7:0]  last_v;
   logic        in_mode;
   logic        vfy;
   logic        armed;
   logic [16:0] pa;
   time         t0;
   logic [31:0] bus_errs = '0;
   logic [31:0] pulse_errs = '0;

   // two counters so bus and pulse checks never race on one variable
   assign errs = bus_errs + pulse_errs;

   // cells start erased, so blank and upper space read all-ones
   initial begin
      for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
      pulses = '0;
      last_pw = '0;
      last_v = 8'hff; // released bus starts at 00, unlike a blank cell
      armed = 1'b0;
   end

   // outside the strap levels nothing but the pins would answer
   assign in_mode = mode_select_pins == 3'h0 && standby_input_n == 1'b0
                    && port6_sel == 2'h3;
   assign vfy = in_mode && !pins.ce_n && !pins.oe_n && pins.pgm_n;

   // released bus shows the inverse of its last value, not a hold
   always_comb begin
      if (pins.data_oe) drv = pins.data;
      else if (vfy) drv = mem[pins.addr];
      else drv = ~last_v;
   end

   // slow setting stays inside the 150 ns output delay
   always @(drv) prom_data_in <= #(slow ? 140 : 20) drv;

   // bookkeeping of bus ownership and misuse
   always @(posedge clk) begin
      if (pins.data_oe || vfy) last_v <= drv;
      if (vfy && pins.data_oe) bus_errs <= bus_errs + 1;
      if (!in_mode && !pins.ce_n) bus_errs <= bus_errs + 1;
   end

   always @(negedge pins.pgm_n) begin
      if (pins.pgm_n === 1'b0) begin
         armed = 1'b1;
         t0 = $time;
         pa = pins.addr;
      end
   end

   // one byte per pulse; a stuck cell keeps bit 0 erased
   always @(posedge pins.pgm_n) begin
      if (armed) begin
         armed = 1'b0;
         last_pw = 32'($time - t0);
         if (in_mode && !pins.ce_n && pins.oe_n && pins.data_oe) begin
            mem[pa] = (mem[pa] & pins.data)
                      | ((stuck_en && pa == stuck_addr) ? 8'h01 : 8'h00);
            pulses = pulses + 1;
         end
         if (pins.addr != pa) pulse_errs = pulse_errs + 1;
         if (pa >= ARRAY_TOP) pulse_errs = pulse_errs + 1;
      end
   end
endmodule

// [pp_writer_test.sv]
`timescale 1ns/1ps
module pp_writer_test
   import pp_pkg::*;
;
   localparam int PW = 20;
   localparam int TRIES = 3;

   logic clk, rst, req_valid, req_ready, rsp_valid, rsp_err, rsp_refused;
   logic slow, stuck_en, standby_input_n, r_err, r_ref;
   pp_cmd_e     req_cmd;
   logic [16:0] req_addr, stuck_addr;
   logic [7:0]  req_wdata, rsp_rdata, prom_data_in, r_data;
   logic [2:0]  mode_select_pins;
   logic [1:0]  port6_sel;
   logic [31:0] pulses, last_pw, errs, p0;
   pp_pins_s    pins;
   int          fails, checks;

   pp_writer #(.PW_CYCLES(PW), .MAX_TRIES(TRIES)) pp_writer_inst (
      .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
      .rsp_refused(rsp_refused), .pins(pins), .prom_data_in(prom_data_in),
      .mode_select_pins(mode_select_pins),
      .standby_input_n(standby_input_n), .port6_sel(port6_sel));

   pp_prom_model pp_prom_model_inst (
      .clk(clk), .pins(pins), .mode_select_pins(mode_select_pins),
      .standby_input_n(standby_input_n), .port6_sel(port6_sel),
      .slow(slow), .stuck_en(stuck_en), .stuck_addr(stuck_addr),
      .prom_data_in(prom_data_in), .pulses(pulses), .last_pw(last_pw),
      .errs(errs));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one request, held until taken, then wait for the answer pulse
   task automatic xfer(pp_cmd_e c, logic [16:0] a, logic [7:0] d);
      int i;
      bit got;
      got = 0;
      for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
      if (req_ready !== 1'b1) begin
         fails++;
         conclude();
      end
      req_cmd = c;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      p0 = pulses;
      for (i = 0; i < 5000 && !got; i++) begin
         @(negedge clk);
         req_valid = 1'b0;
         if (i == 0) check("busy ready", req_ready, 1'b0);
         if (rsp_valid === 1'b1) begin
            got = 1;
            r_data = rsp_rdata;
            r_err = rsp_err;
            r_ref = rsp_refused;
         end
      end
      if (!got) begin
         fails++;
         conclude();
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_idle();
      check("mode pins", mode_select_pins, MODE_PROM);
      check("standby", standby_input_n, STANDBY_INPUT_N_PROM);
      check("port6", port6_sel, PORT6_PROM);
      check("idle ce_n", pins.ce_n, 1'b1);
      check("idle data_oe", pins.data_oe, 1'b0);
   endtask

   // blank and upper-range locations read all-ones, no pulse
   task automatic t_blank();
      logic [16:0] al [3];
      al = '{17'h00000, 17'h0f680, 17'h1ffff};
      foreach (al[k]) begin
         xfer(PP_CMD_READ, al[k], 8'h00);
         check("blank data", r_data, BLANK_BYTE);
      end
      check("blank pulses", pulses, p0);
   endtask

   // program then verify, slow chip, then the last array byte
   task automatic t_program();
      xfer(PP_CMD_PROGRAM, 17'h00a5c, 8'h3c);
      check("prog err", {r_err, r_ref}, 2'b00);
      check("prog pulses", pulses, p0 + 1);
      check("pulse width", last_pw, PW * CLK_PERIOD_NS);
      slow = 1'b1;
      xfer(PP_CMD_READ, 17'h00a5c, 8'h00);
      check("verify data", r_data, 8'h3c);
      slow = 1'b0;
      xfer(PP_CMD_PROGRAM, 17'h0f67f, 8'h5a);
      check("edge pulses", pulses, p0 + 1);
      xfer(PP_CMD_READ, 17'h0f67f, 8'h00);
      check("edge data", r_data, 8'h5a);
   endtask

   // an all-ones byte is answered without a pulse
   task automatic t_blank_prog();
      xfer(PP_CMD_PROGRAM, 17'h00100, 8'hff);
      check("ff pulses", pulses, p0);
      check("ff err", {r_err, r_ref}, 2'b00);
   endtask

   // upper addresses are refused and stay erased
   task automatic t_refuse();
      xfer(PP_CMD_PROGRAM, 17'h0f680, 8'h00);
      check("top refused", r_ref, 1'b1);
      check("top pulses", pulses, p0);
      xfer(PP_CMD_PROGRAM, 17'h1ffff, 8'h00);
      check("max refused", r_ref, 1'b1);
      xfer(PP_CMD_READ, 17'h0f680, 8'h00);
      check("top data", r_data, BLANK_BYTE);
   endtask

   // a cell that will not program exhausts the retries
   task automatic t_stuck();
      stuck_en = 1'b1;
      stuck_addr = 17'h00200;
      xfer(PP_CMD_PROGRAM, 17'h00200, 8'h00);
      check("stuck err", r_err, 1'b1);
      check("stuck pulses", pulses, p0 + TRIES);
      check("stuck data", r_data, 8'h01);
      stuck_en = 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      fails = 0;
      checks = 0;
      rst = 1'b1;
      req_valid = 1'b0;
      req_cmd = PP_CMD_READ;
      req_addr = '0;
      req_wdata = '0;
      slow = 1'b0;
      stuck_en = 1'b0;
      stuck_addr = '0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_idle();
      t_blank();
      t_program();
      t_blank_prog();
      t_refuse();
      t_stuck();
      t_idle();
      check("chip misuse", errs, 32'h0);
      conclude();
   end
endmodule
